// ### bench/sleep_core_model.sv
`timescale 1ns/100ps
// Core side: register port master and sleep instruction source
module sleep_core_model (
	input  wire logic                      clock,
	input  wire logic [7:0]                rdata,
	output sleep_power_pkg::reg_req_t      req,
	output logic                           sleep_instr
);
	import sleep_power_pkg::*;
	// Idle bus at time zero
	initial begin
		req = '0;
		sleep_instr = 1'b0;
	end
	// One write; address and data inverted after so stale values cannot pass for live ones
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	// One read; data taken in the cycle after the strobe only
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
		#1 d = rdata;
	endtask
	// One-cycle sleep instruction
	task automatic sleep_pulse();
		@(posedge clock);
		sleep_instr <= 1'b1;
		@(posedge clock);
		sleep_instr <= 1'b0;
	endtask
	// Two-write sequence; gap is idle cycles added to the one idle cycle between the writes
	task automatic bod_seq(input int gap);
		wr(ADDR_SYSTEM_CONTROL, 8'h60);
		repeat (gap) @(posedge clock);
		wr(ADDR_SYSTEM_CONTROL, 8'h40);
	endtask
endmodule

// ### bench/sleep_power_reset_control_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the sleep, gating and reset block
module sleep_power_reset_control_tb_top;
	import sleep_power_pkg::*;
	logic                       clock = 1'b0;       // 200 MHz
	logic                       rst_n = 1'b0;       // Held for 8 cycles
	reg_req_t                   req;                // From core model
	logic       [7:0]           rdata;              // Read data
	logic                       sleep_instr;        // From core model
	reset_src_t                 src = '0;           // Reset sources
	logic       [2:0]           en = 3'b000;        // Detector, comparator select, converter
	logic                       wdog_en = 1'b1;     // Watchdog enable level
	gates_t                     gates;              // Gate outputs
	logic                       sleeping;           // Asleep
	logic       [2:0]           mode;               // Mode copy
	logic                       bod_off;            // Detector off for sleep
	logic                       int_rst;            // Internal reset
	logic                       port_rst;           // Port reset
	logic                       ref_on;             // Reference power
	logic                       mux_blk;            // Comparator mux blocked
	logic       [7:0]           d;                  // Read scratch
	int                         bad_count = 0;      // Mismatches
	int                         cmp_count = 0;      // Comparisons
	always #2.5 clock = ~clock;
	// Short delay counts keep reset stretches cheap to simulate
	sleep_power_reset_control #(.DELAY_SHORT(20'h0_0008), .DELAY_LONG(20'h0_0010))
	i_sleep_power_reset_control (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
		.sleep_instr(sleep_instr), .src(src), .watchdog_enabled(wdog_en),
		.brownout_detect_enabled(en[2]), .comparator_reference_select(en[1]),
		.converter_enabled(en[0]), .startup_time_fuse(1'b0), .gates(gates),
		.sleeping(sleeping), .sleep_mode_select(mode), .brownout_off_in_sleep(bod_off),
		.internal_reset(int_rst), .port_reset(port_rst), .reference_on(ref_on),
		.comparator_mux_blocked(mux_blk));
	sleep_core_model i_sleep_core_model (.clock(clock), .rdata(rdata), .req(req),
		.sleep_instr(sleep_instr));
	// Verdict
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Case-equal compare
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Cycles until internal reset drops, bounded so a stuck reset ends the run
	task automatic wait_release(output int n);
		n = 0;
		while (int_rst !== 1'b0) begin
			@(posedge clock);
			#1;
			n++;
			if (n > 40) begin
				chk(8'h01, 8'h00);
				stop_test();
			end
		end
	endtask
	// Reset values, reserved bits, unmapped address
	task automatic t_regs();
		logic [3:0] a;
		for (int i = 0; i < 6; i++) begin
			a = (i == 4) ? 4'h5 : i[3:0];
			i_sleep_core_model.rd(a, d);
			chk(d, 8'h00);
		end
		i_sleep_core_model.wr(ADDR_POWER_REDUCTION, 8'hff);
		i_sleep_core_model.rd(ADDR_POWER_REDUCTION, d);
		chk(d, 8'h0f);
		chk({4'h0, gates}, 8'h0f);
		chk({7'h0, mux_blk}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			i_sleep_core_model.wr(ADDR_POWER_REDUCTION, 8'h01 << i);
			@(posedge clock);
			#1;
			chk({4'h0, gates}, 8'h01 << i);
		end
	endtask
	// Every defined mode code, then sleep allow gating
	task automatic t_sleep();
		logic [2:0] codes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b110};
		foreach (codes[i]) begin
			i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, {4'h0, codes[i], 1'b0});
			i_sleep_core_model.rd(ADDR_SLEEP_MODE_CONTROL, d);
			chk(d, {4'h0, codes[i], 1'b0});
			chk({5'h0, mode}, {5'h0, codes[i]});
		end
		i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, 8'h04);
		i_sleep_core_model.sleep_pulse();
		@(posedge clock);
		#1;
		chk({7'h0, sleeping}, 8'h00);
		i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, 8'h05);
		i_sleep_core_model.sleep_pulse();
		@(posedge clock);
		#1;
		chk({7'h0, sleeping}, 8'h01);
		i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, 8'h04);
		@(posedge clock);
		#1;
		chk({7'h0, sleeping}, 8'h00);
	endtask
	// Timed sequence inside and outside the window; count the reads that show the bit active
	task automatic t_bod();
		int hits;
		for (int g = 0; g < 2; g++) begin
			i_sleep_core_model.bod_seq(g * 6);
			hits = 0;
			repeat (12) begin
				i_sleep_core_model.rd(ADDR_SYSTEM_CONTROL, d);
				hits += (d[BOD_SLEEP_BIT] === 1'b1);
			end
			chk(hits[7:0], (g == 0) ? 8'h02 : 8'h00);
		end
		// Sleep while the bit is active, then sleep with it cleared
		i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, 8'h05);
		i_sleep_core_model.bod_seq(0);
		repeat (2) @(posedge clock);
		i_sleep_core_model.sleep_pulse();
		@(posedge clock);
		#1;
		chk({7'h0, bod_off}, 8'h01);
		i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, 8'h04);
		i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, 8'h05);
		i_sleep_core_model.sleep_pulse();
		@(posedge clock);
		#1;
		chk({7'h0, bod_off}, 8'h00);
		i_sleep_core_model.wr(ADDR_SLEEP_MODE_CONTROL, 8'h04);
	endtask
	// Reference power for all input combinations
	task automatic t_ref();
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			en <= i[2:0];
			repeat (3) @(posedge clock);
			chk({7'h0, ref_on}, {7'h0, (i != 0)});
		end
		en <= 3'b100;
	endtask
	// Each source: immediate assertion, register clear, stretched release
	task automatic t_src();
		int n;
		for (int i = 0; i < 5; i++) begin
			i_sleep_core_model.wr(ADDR_POWER_REDUCTION, 8'h05);
			@(posedge clock);
			src <= 5'h01 << i;
			#1;
			chk({6'h0, int_rst, port_rst}, 8'h03);
			if (i != 2) repeat (3) @(posedge clock);
			else @(posedge clock);
			chk({7'h0, int_rst}, 8'h01);
			src <= '0;
			@(posedge clock);
			wait_release(n);
			chk({7'h0, (n >= 8 && n <= 12)}, 8'h01);
			i_sleep_core_model.rd(ADDR_POWER_REDUCTION, d);
			chk(d, 8'h00);
		end
		wdog_en <= 1'b0;
		en <= 3'b000;
		@(posedge clock);
		src <= 5'b0_0110;
		repeat (4) @(posedge clock);
		chk({7'h0, int_rst}, 8'h00);
		src <= '0;
	endtask
	// Main sequence
	initial begin
		int n;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		wait_release(n);
		t_regs();
		t_sleep();
		t_bod();
		t_ref();
		t_src();
		stop_test();
	end
endmodule

// ### design/sleep_power_pkg.sv
package sleep_power_pkg;

	// Register addresses on the plain register port
	localparam logic [3:0] ADDR_SLEEP_MODE_CONTROL = 4'h0; // Sleep mode and sleep allow
	localparam logic [3:0] ADDR_SYSTEM_CONTROL     = 4'h1; // Brown-out sleep bits
	localparam logic [3:0] ADDR_POWER_REDUCTION    = 4'h2; // Peripheral clock gates
	localparam logic [3:0] ADDR_RESET_STATUS       = 4'h3; // Live synchronised reset sources

	// Field positions
	localparam int SLEEP_ALLOW_BIT     = 0;
	localparam int SLEEP_MODE_LSB      = 1;
	localparam int BOD_SLEEP_CE_BIT    = 5;
	localparam int BOD_SLEEP_BIT       = 6;
	localparam int GATE_CONVERTER_BIT  = 0;
	localparam int GATE_XCVR_BIT       = 1;
	localparam int GATE_SPI_BIT        = 2;
	localparam int GATE_TIMER16_BIT    = 3;

	// Reset values
	localparam logic [7:0] SLEEP_MODE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] SYSTEM_CONTROL_RESET     = 8'h00;
	localparam logic [7:0] POWER_REDUCTION_RESET    = 8'h00;
	localparam logic [7:0] POWER_REDUCTION_MASK     = 8'h0f;

	// Timing counts in system clock cycles
	localparam logic [2:0] BOD_CHANGE_WINDOW = 3'h4; // Cycles the change enable stays open
	localparam logic [2:0] BOD_ACTIVE_DELAY  = 3'h3; // Set to active
	localparam logic [2:0] BOD_ACTIVE_HOLD   = 3'h3; // Active to auto clear
	localparam int         DELAY_WIDTH       = 20;
	localparam logic [1:0] SYNC_SETTLE       = 2'h2; // Synchroniser latency cover

	// Sleep mode codes
	typedef enum logic [2:0] {
		MODE_IDLE       = 3'b000,
		MODE_NOISE_RED  = 3'b001,
		MODE_POWER_DOWN = 3'b010,
		MODE_POWER_SAVE = 3'b011,
		MODE_STANDBY    = 3'b110
	} sleep_mode_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// Raw reset sources
	typedef struct packed {
		logic power_low;   // Supply below power-on level
		logic pin_low;     // External reset pin held low
		logic watchdog;    // Watchdog expiry pulse
		logic brownout;    // Low-supply indication
		logic scan_reset;  // Test-port reset register bit
	} reset_src_t;

	// Peripheral gate outputs
	typedef struct packed {
		logic timer16;
		logic serial_peripheral;
		logic serial_transceiver;
		logic converter;
	} gates_t;

endpackage

// ### design/sleep_power_reset_control.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
module sleep_power_reset_control
	import sleep_power_pkg::*;
#(
	parameter logic [DELAY_WIDTH-1:0] DELAY_SHORT = 20'h0_0040, // Short fuse time-out
	parameter logic [DELAY_WIDTH-1:0] DELAY_LONG  = 20'hF_4240  // Long fuse time-out
) (
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	input  wire sleep_power_pkg::reg_req_t     req,
	output logic       [7:0]                   rdata,
	input  wire logic                          sleep_instr,
	input  wire sleep_power_pkg::reset_src_t   src,
	input  wire logic                          watchdog_enabled,
	input  wire logic                          brownout_detect_enabled,
	input  wire logic                          comparator_reference_select,
	input  wire logic                          converter_enabled,
	input  wire logic                          startup_time_fuse,
	output sleep_power_pkg::gates_t            gates,
	output logic                               sleeping,
	output logic       [2:0]                   sleep_mode_select,
	output logic                               brownout_off_in_sleep,
	output logic                               internal_reset,
	output logic                               port_reset,
	output logic                               reference_on,
	output logic                               comparator_mux_blocked
);
	import sleep_power_pkg::*;

	// Registers held by the block
	logic [7:0] sleep_mode_control;   // Mode field and allow bit
	logic [7:0] power_reduction;      // Low nibble gates
	logic       bod_ce;               // Change enable, self closing
	logic [2:0] ce_count;             // Change window counter
	logic       bod_pending;          // Set, not yet active
	logic       bod_active;           // Brown-out sleep bit active
	logic [2:0] bod_count;            // Delay and hold counter

	// Synchronised asynchronous sources
	logic [4:0] src_meta;
	logic [4:0] src_sync;
	logic       any_src_sync;
	logic       any_src_raw;
	logic [1:0] settle;               // Holds stretch until sources reach src_sync
	logic [DELAY_WIDTH-1:0] delay_count;
	logic       stretch;

	// Raw combination of sources, only used asynchronously, for stretch and both resets.
	// Disabled watchdog and brown-out sources are masked here so that a
	// detector that is switched off can never pull the device into reset.
	// This net is never read by clocked logic as data; it only sets the
	// reset flops directly, so no clock has to run for reset to assert.
	// A glitch on any source will assert reset: that is the safe side.
	// Minimum pin pulse width is left to the pad filter outside this block.
	assign any_src_raw = src.power_low | src.pin_low | src.scan_reset
		| (src.watchdog & watchdog_enabled)
		| (src.brownout & brownout_detect_enabled);

	// Two-flop synchroniser for every source.
	// Only src_sync is read by logic; src_meta may go metastable and is
	// read by nothing but the second stage.
	// The enable masks are applied before the first flop on purpose, so that
	// the synchronised copy and the raw net always agree on what counts.
	// Latency is two cycles, covered by the settle counter further down.
	// The flops have no reset so that they keep tracking through any reset.
	always_ff @(posedge clock) begin
		src_meta <= {src.power_low, src.pin_low, src.watchdog & watchdog_enabled,
			src.brownout & brownout_detect_enabled, src.scan_reset};
		src_sync <= src_meta;
	end
	assign any_src_sync = |src_sync;

	// Sleep mode control register write.
	// Only the low nibble is stored: mode field and allow bit.
	// Reserved mode codes are stored as written; decoding is left to the
	// clock controller, which treats them as no sleep at all.
	// Internal reset clears the register as well as rst_n, so a watchdog
	// or brown-out reset returns software to a known power state.
	// Writes during internal reset are dropped by that priority.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sleep_mode_control <= SLEEP_MODE_CONTROL_RESET;
		end else if (internal_reset) begin
			sleep_mode_control <= SLEEP_MODE_CONTROL_RESET;
		end else if (req.wr && req.addr == ADDR_SLEEP_MODE_CONTROL) begin
			sleep_mode_control <= {4'h0, req.wdata[3:0]};
		end
	end

	// Power reduction register; upper nibble never stored.
	// Masking on write rather than on read keeps the reserved bits at zero
	// everywhere they are used, including the gate outputs below.
	// A gate bit only stops the module clock; the module keeps its state,
	// so clearing the bit resumes it where it stopped.
	// Software is expected to disable the converter before gating it, and to
	// reinitialise the serial modules after ungating; this block cannot know.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			power_reduction <= POWER_REDUCTION_RESET;
		end else if (internal_reset) begin
			power_reduction <= POWER_REDUCTION_RESET;
		end else if (req.wr && req.addr == ADDR_POWER_REDUCTION) begin
			power_reduction <= req.wdata & POWER_REDUCTION_MASK;
		end
	end

	// Timed change sequence for the brown-out sleep bit.
	// The first write sets both the bit and its change enable and opens a
	// window of four cycles. Any later write to the register inside that
	// window that does not set both bits again completes the change.
	// A write that sets both bits again restarts the window rather than
	// completing the change, which matches a software retry.
	// The window closes on its own, so a stray write later does nothing.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bod_ce      <= 1'b0;
			ce_count    <= 3'h0;
			bod_pending <= 1'b0;
		end else if (internal_reset) begin
			bod_ce      <= 1'b0;
			ce_count    <= 3'h0;
			bod_pending <= 1'b0;
		end else begin
			bod_pending <= 1'b0;
			if (bod_ce) begin
				// Window closes on its own after four cycles
				ce_count <= ce_count - 3'h1;
				if (ce_count == 3'h1) begin
					bod_ce <= 1'b0;
				end
			end
			if (req.wr && req.addr == ADDR_SYSTEM_CONTROL) begin
				if (req.wdata[BOD_SLEEP_BIT] && req.wdata[BOD_SLEEP_CE_BIT]) begin
					bod_ce   <= 1'b1;
					ce_count <= BOD_CHANGE_WINDOW;
				end else if (bod_ce) begin
					// Second write inside the window completes the change
					bod_ce      <= 1'b0;
					bod_pending <= 1'b1;
				end
			end
		end
	end

	// Brown-out sleep bit delay to active and automatic clear.
	// One counter serves both phases: it first times the delay to active,
	// then is reloaded to time the hold before the automatic clear.
	// The pending pulse itself already spends one of the delay cycles,
	// hence the load of one less than the delay count.
	// A sleep instruction must land while the bit is active; outside that
	// short spot the detector stays on during sleep.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bod_active <= 1'b0;
			bod_count  <= 3'h0;
		end else if (internal_reset) begin
			bod_active <= 1'b0;
			bod_count  <= 3'h0;
		end else if (bod_pending) begin
			bod_count <= BOD_ACTIVE_DELAY - 3'h1;
		end else if (bod_count != 3'h0) begin
			bod_count <= bod_count - 3'h1;
			if (bod_count == 3'h1) begin
				bod_active <= ~bod_active;
				if (!bod_active) begin
					bod_count <= BOD_ACTIVE_HOLD;
				end
			end
		end
	end

	// Sleep entry and wake.
	// The sleep instruction has effect only while the allow bit is set.
	// The detector-off state is captured at entry and held for the whole
	// sleep period, even though the brown-out sleep bit clears itself soon.
	// There is no wake logic here: software ends the sleep state by
	// clearing the allow bit after wake-up, as it should anyway.
	always_ff @(posedge clock) begin
		if (!rst_n || internal_reset) begin
			sleeping              <= 1'b0;
			brownout_off_in_sleep <= 1'b0;
		end else if (sleep_instr && sleep_mode_control[SLEEP_ALLOW_BIT]) begin
			sleeping              <= 1'b1;
			brownout_off_in_sleep <= bod_active;
		end else if (!sleep_mode_control[SLEEP_ALLOW_BIT]) begin
			// Clearing allow after wake-up ends the sleep state
			sleeping              <= 1'b0;
			brownout_off_in_sleep <= 1'b0;
		end
	end

	// Stretch flag for the internal reset.
	// It is set at once by any raw source, with no clock needed, and the
	// settle counter then covers the gap until that source reaches the
	// synchroniser output. Without it a source shorter than the two-cycle
	// latency, such as the one-cycle watchdog pulse, would let the stretch
	// drop before the delay counter had ever been loaded.
	// The set path assigns constants only, so it is safe as an async set.
	always_ff @(posedge clock or posedge any_src_raw) begin
		if (any_src_raw) begin
			stretch <= 1'b1;
			settle  <= SYNC_SETTLE;
		end else if (!rst_n) begin
			stretch <= 1'b1;
			settle  <= 2'h0;
		end else if (any_src_sync) begin
			// A synchronised source still stands: keep holding
			stretch <= 1'b1;
		end else if (settle != 2'h0) begin
			settle <= settle - 2'h1;
		end else if (delay_count == '0) begin
			// Time-out expired with every source quiet
			stretch <= 1'b0;
		end
	end

	// Delay counter, synchronous only.
	// Reloaded for as long as any source stands, so timing starts at the
	// last source to fall, or at the fall of the watchdog pulse.
	// The fuse picks the short or the long time-out.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			delay_count <= '0;
		end else if (any_src_sync) begin
			delay_count <= startup_time_fuse ? DELAY_LONG : DELAY_SHORT;
		end else if (delay_count != '0) begin
			delay_count <= delay_count - 1'b1;
		end
	end

	// Port reset follows any source immediately, no clock needed.
	// Asynchronous set, synchronous release through the stretch flag, so
	// the release edge is clean for every flop it reaches.
	// A power-low or pin source reasserts it with no delay at all.
	// The release still waits for the full time-out period.
	// Kept as its own flop so that port logic loads it separately.
	always_ff @(posedge clock or posedge any_src_raw) begin
		if (any_src_raw) begin
			port_reset <= 1'b1;
		end else begin
			port_reset <= stretch;
		end
	end

	// Internal reset, asserted immediately, released after time-out.
	// The synchronised sources are ORed in as well as the stretch flag, as
	// a second guard should the settle counter ever be outrun.
	// The mode, power reduction, brown-out sleep and sleep state registers are cleared while it stands.
	// Brown-out only counts while detection is enabled, watchdog only while
	// the watchdog is enabled; the masks sit in front of the synchroniser.
	always_ff @(posedge clock or posedge any_src_raw) begin
		if (any_src_raw) begin
			internal_reset <= 1'b1;
		end else begin
			internal_reset <= stretch | any_src_sync;
		end
	end

	// Registered outputs: gates, mode, reference.
	// All come straight from flops; the one cycle of lag against the
	// registers is harmless for clock gates and for the mode select.
	// The reference is powered for the detector, the comparator reference
	// select or the converter; software must still allow it to start up.
	// The comparator loses the converter multiplexer with the converter gate.
	always_ff @(posedge clock) begin
		gates.timer16            <= power_reduction[GATE_TIMER16_BIT];
		gates.serial_peripheral  <= power_reduction[GATE_SPI_BIT];
		gates.serial_transceiver <= power_reduction[GATE_XCVR_BIT];
		gates.converter          <= power_reduction[GATE_CONVERTER_BIT];
		comparator_mux_blocked   <= power_reduction[GATE_CONVERTER_BIT];
		sleep_mode_select        <= sleep_mode_control[SLEEP_MODE_LSB +: 3];
		reference_on <= brownout_detect_enabled | comparator_reference_select
			| converter_enabled;
	end

	// Register read, data one cycle later.
	// Read data stand for one cycle only and are zero otherwise, so a
	// stale value can never pass for a fresh one.
	// Reserved bits of every register read as zero.
	// The status address shows the live synchronised sources for debug.
	// Unmapped addresses read as zero.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				ADDR_SLEEP_MODE_CONTROL: rdata <= sleep_mode_control;
				ADDR_SYSTEM_CONTROL:
					rdata <= {1'b0, bod_active, bod_ce, 5'h00};
				ADDR_POWER_REDUCTION: rdata <= {4'h0, power_reduction[3:0]};
				ADDR_RESET_STATUS:
					rdata <= {3'h0, src_sync};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// Checks.
	// Assertions watch what this block drives; they are disabled during
	// rst_n, and the brown-out sequence checks also during internal reset,
	// since reset may cut a sequence short at any point.
	// Covers mark the main scenarios a bench should reach.
	a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
		req.rd && req.addr == ADDR_POWER_REDUCTION |=> rdata[7:4] == 4'h0)
		else $error("reserved bits not zero");
	a_sleep_needs_allow: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(sleeping) |-> $past(sleep_mode_control[SLEEP_ALLOW_BIT]))
		else $error("sleep without allow");
	a_bod_active_delay: assert property (@(posedge clock) disable iff (!rst_n || internal_reset)
		bod_pending && !bod_active |-> !bod_active[*3] ##1 bod_active)
		else $error("brown-out sleep not active after three");
	a_bod_auto_clear: assert property (@(posedge clock) disable iff (!rst_n || internal_reset)
		$rose(bod_active) |-> bod_active[*3] ##1 !bod_active)
		else $error("brown-out sleep not cleared");
	a_ce_window: assert property (@(posedge clock) disable iff (!rst_n || internal_reset)
		$rose(bod_ce) |-> ##[1:4] !bod_ce)
		else $error("change window too long");
	a_reset_immediate: assert property (@(posedge clock) disable iff (!rst_n)
		src_sync[4] |-> internal_reset)
		else $error("power-low without reset");
	a_reference_on: assert property (@(posedge clock) disable iff (!rst_n)
		converter_enabled |=> reference_on)
		else $error("reference off with converter");
	a_gate_timer: assert property (@(posedge clock) disable iff (!rst_n)
		power_reduction[GATE_TIMER16_BIT] |=> gates.timer16)
		else $error("timer gate lost");
	a_mode_follow: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> sleep_mode_select == $past(sleep_mode_control[3:1]))
		else $error("mode output stale");
	c_sleep: cover property (@(posedge clock) $rose(sleeping));
	c_bod_off: cover property (@(posedge clock) $rose(brownout_off_in_sleep));
	c_release: cover property (@(posedge clock) $fell(internal_reset));
	c_bod_active: cover property (@(posedge clock) $rose(bod_active));
	// A raw source already standing at an edge has set both resets
	a_port_reset_async: assert property (@(posedge clock) disable iff (!rst_n)
		any_src_raw |-> port_reset && internal_reset)
		else $error("reset not asserted by source");
	// Release only once the delay counter has run down
	a_release_timed: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(internal_reset) |-> delay_count == '0)
		else $error("reset released before time-out");
	// Detector off in sleep only if the bit was active at entry
	a_bod_off_active: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(brownout_off_in_sleep) |-> $past(bod_active))
		else $error("detector off without active bit");
endmodule
